// ---- hdl/temp_sensor_core.sv ----
module temp_sensor_core #(
   parameter int unsigned ACT_CONV_CYCLES = temp_core_pkg::ACT_CONV_CYC,
   parameter int unsigned TIMEOUT_CYCLES = temp_core_pkg::TIMEOUT_CYC,
   parameter int unsigned MS_CYCLES = temp_core_pkg::MS_CYC
) (
   input wire logic clk_i,
   input wire logic reset_i,
   // Chain pins
   input wire logic chain_rx_i,
   output logic chain_tx_o,
   // Own transmit path, received bytes and commands from the serial engine
   input wire logic own_send_i,
   input wire logic own_bit_i,
   input wire logic byte_seen_i,
   input wire logic [7:0] byte_data_i,
   input wire logic [3:0] cmd_addr_i,
   input wire logic cmd_global_i,
   input wire logic cmd_valid_i,
   input wire logic addr_load_i,
   input wire logic [3:0] addr_value_i,
   // Configuration
   input wire logic mode_wr_i,
   input wire logic [1:0] mode_i,
   input wire logic [1:0] conversion_rate_field_i,
   input wire logic extended_range_select_i,
   input wire temp_core_pkg::limit_wr_t limit_wr_i,
   // Analog front end sample, signed sixteenths of a degree
   input wire logic signed [15:0] raw_temp_i,
   // Status
   output logic [1:0] mode_o,
   output logic [12:0] result_o,
   output logic result_valid_o,
   output logic result_ext_o,
   output logic converting_o,
   output logic [12:0] high_limit_o,
   output logic [12:0] low_limit_o,
   output logic iface_reset_o,
   output logic iface_synced_o,
   output logic addr_match_o,
   output logic [3:0] own_addr_o
);
   import temp_core_pkg::*;

   // ---------------------------------------------------------------
   // Pin synchroniser
   // ---------------------------------------------------------------
   logic rx_meta_q;
   logic rx_sync_q;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rx_meta_q <= 1'b1;
         rx_sync_q <= 1'b1;
      end else begin
         rx_meta_q <= chain_rx_i;
         rx_sync_q <= rx_meta_q;
      end
   end

   // Pass-through or own data; two sync stages plus this register give three cycles
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         chain_tx_o <= 1'b1;
      end else begin
         chain_tx_o <= own_send_i ? own_bit_i : rx_sync_q;
      end
   end

   // ---------------------------------------------------------------
   // Conversion sequencer
   // ---------------------------------------------------------------
   conv_state_t state_q;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] wait_cyc;
   logic conv_done;
   logic [1:0] mode_q;

   // Idle delay is the period less the conversion itself
   always_comb begin
      case (conversion_rate_field_i)
         2'h0: wait_cyc = CNT_W'(PERIOD_MS_0 * MS_CYCLES - ACT_CONV_CYCLES);
         2'h1: wait_cyc = CNT_W'(PERIOD_MS_1 * MS_CYCLES - ACT_CONV_CYCLES);
         2'h2: wait_cyc = CNT_W'(PERIOD_MS_2 * MS_CYCLES - ACT_CONV_CYCLES);
         default: wait_cyc = CNT_W'(PERIOD_MS_3 * MS_CYCLES - ACT_CONV_CYCLES);
      endcase
   end

   assign conv_done = (state_q == CV_RUN) && (cnt_q == CNT_W'(ACT_CONV_CYCLES - 1));

   // Reset starts a conversion straight away; time base is cnt_q
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_q <= CV_RUN;
         cnt_q <= '0;
         converting_o <= 1'b1;
      end else begin
         case (state_q)
            CV_RUN: begin
               if (conv_done) begin
                  cnt_q <= '0;
                  // Bit 1 alone selects continuous, so 11 behaves as 10
                  state_q <= mode_q[1] ? CV_WAIT : CV_IDLE;
                  converting_o <= 1'b0;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            CV_WAIT: begin
               if (!mode_q[1]) begin
                  state_q <= CV_IDLE;
                  cnt_q <= '0;
               end else if (cnt_q >= wait_cyc - 1'b1) begin
                  state_q <= CV_RUN;
                  converting_o <= 1'b1;
                  cnt_q <= '0;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            default: begin
               cnt_q <= '0;
               if (mode_q != MODE_SHUTDOWN) begin
                  state_q <= CV_RUN;
                  converting_o <= 1'b1;
               end
            end
         endcase
      end
   end

   // Mode field; one-shot reverts to shutdown once its conversion ends
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         mode_q <= MODE_CONT;
      end else if (mode_wr_i) begin
         mode_q <= mode_i;
      end else if (conv_done && mode_q == MODE_ONE_SHOT) begin
         mode_q <= MODE_SHUTDOWN;
      end
   end
   assign mode_o = mode_q;

   // ---------------------------------------------------------------
   // Result formatting
   // ---------------------------------------------------------------
   logic [12:0] fmt;
   logic signed [15:0] norm_max_s;
   logic signed [15:0] norm_min_s;
   assign norm_max_s = signed'({3'h0, NORM_MAX});
   assign norm_min_s = signed'({3'h7, NORM_MIN});

   // Extended select is consulted here at conversion end, and by the limit writes
   always_comb begin
      fmt = raw_temp_i[12:0];
      if (!extended_range_select_i) begin
         if (raw_temp_i > norm_max_s) begin
            fmt = NORM_MAX;
         end else if (raw_temp_i < norm_min_s) begin
            fmt = NORM_MIN;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         result_o <= '0;
         result_valid_o <= 1'b0;
         result_ext_o <= 1'b0;
      end else if (conv_done) begin
         result_o <= fmt;
         result_valid_o <= 1'b1;
         result_ext_o <= extended_range_select_i;
      end
   end

   // ---------------------------------------------------------------
   // Limit registers
   // ---------------------------------------------------------------
   // Extension bit only written in extended mode and kept otherwise
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         high_limit_o <= '0;
         low_limit_o <= '0;
      end else begin
         if (limit_wr_i.wr_high) begin
            high_limit_o[11:0] <= limit_wr_i.value[11:0];
            if (extended_range_select_i) begin
               high_limit_o[12] <= limit_wr_i.value[12];
            end
         end
         if (limit_wr_i.wr_low) begin
            low_limit_o[11:0] <= limit_wr_i.value[11:0];
            if (extended_range_select_i) begin
               low_limit_o[12] <= limit_wr_i.value[12];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Interface timeout and addressing
   // ---------------------------------------------------------------
   logic [CNT_W-1:0] idle_q;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         idle_q <= '0;
         iface_reset_o <= 1'b0;
         iface_synced_o <= 1'b0;
      end else begin
         iface_reset_o <= 1'b0;
         if (byte_seen_i) begin
            idle_q <= '0;
            if (!iface_synced_o) begin
               iface_synced_o <= (byte_data_i == CAL_BYTE);
            end
         end else if (iface_synced_o) begin
            if (idle_q == CNT_W'(TIMEOUT_CYCLES - 1)) begin
               idle_q <= '0;
               iface_synced_o <= 1'b0;
               iface_reset_o <= 1'b1;
            end else begin
               idle_q <= idle_q + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         own_addr_o <= ADDR_RESET;
         addr_match_o <= 1'b0;
      end else begin
         if (addr_load_i) begin
            own_addr_o <= addr_value_i;
         end
         addr_match_o <= cmd_valid_i && (cmd_global_i || cmd_addr_i == own_addr_o);
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_pass_through;
      @(posedge clk_i) disable iff (reset_i)
      !own_send_i |=> chain_tx_o == $past(rx_sync_q);
   endproperty
   a_pass_through: assert property (p_pass_through) else $error("pass-through broken");

   property p_result_on_done;
      @(posedge clk_i) disable iff (reset_i)
      conv_done |=> result_valid_o && result_o == $past(fmt);
   endproperty
   a_result_on_done: assert property (p_result_on_done) else $error("result not stored");

   property p_saturate;
      @(posedge clk_i) disable iff (reset_i)
      (!extended_range_select_i && raw_temp_i > norm_max_s) |-> fmt == NORM_MAX;
   endproperty
   a_saturate: assert property (p_saturate) else $error("no saturation");

   property p_ext_kept;
      @(posedge clk_i) disable iff (reset_i)
      !extended_range_select_i |=> high_limit_o[12] == $past(high_limit_o[12]);
   endproperty
   a_ext_kept: assert property (p_ext_kept) else $error("extension bit changed");

   property p_one_shot_back;
      @(posedge clk_i) disable iff (reset_i)
      (conv_done && mode_q == MODE_ONE_SHOT && !mode_wr_i) |=> mode_q == MODE_SHUTDOWN;
   endproperty
   a_one_shot_back: assert property (p_one_shot_back) else $error("one-shot stuck");

   property p_shutdown_idle;
      @(posedge clk_i) disable iff (reset_i)
      (conv_done && !mode_q[1]) |=> state_q == CV_IDLE;
   endproperty
   a_shutdown_idle: assert property (p_shutdown_idle) else $error("not idle");

   property p_cont_wait;
      @(posedge clk_i) disable iff (reset_i)
      (conv_done && mode_q[1]) |=> state_q == CV_WAIT;
   endproperty
   a_cont_wait: assert property (p_cont_wait) else $error("no rate wait");

   property p_byte_restart;
      @(posedge clk_i) disable iff (reset_i)
      byte_seen_i |=> idle_q == '0 && !iface_reset_o;
   endproperty
   a_byte_restart: assert property (p_byte_restart) else $error("timer not restarted");

   property p_global;
      @(posedge clk_i) disable iff (reset_i)
      (cmd_valid_i && cmd_global_i) |=> addr_match_o;
   endproperty
   a_global: assert property (p_global) else $error("global ignored");

   property p_ext_kept_low;
      @(posedge clk_i) disable iff (reset_i)
      !extended_range_select_i |=> low_limit_o[12] == $past(low_limit_o[12]);
   endproperty
   a_ext_kept_low: assert property (p_ext_kept_low) else $error("low extension bit changed");

   property p_timeout_drop;
      @(posedge clk_i) disable iff (reset_i)
      iface_reset_o |-> !iface_synced_o;
   endproperty
   a_timeout_drop: assert property (p_timeout_drop) else $error("sync kept on timeout");
endmodule

// ---- hdl/temp_core_pkg.sv ----
package temp_core_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ = 125000000;
   localparam int unsigned ACT_CONV_MS = 26;
   localparam int unsigned TIMEOUT_MS = 28;
   localparam int unsigned ACT_CONV_CYC = ACT_CONV_MS * (CLK_HZ / 1000);
   localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
   // Conversion periods in milliseconds, indexed by rate field
   localparam int unsigned PERIOD_MS_0 = 4000;
   localparam int unsigned PERIOD_MS_1 = 1000;
   localparam int unsigned PERIOD_MS_2 = 250;
   localparam int unsigned PERIOD_MS_3 = 125;
   localparam int unsigned MS_CYC = CLK_HZ / 1000;
   localparam int unsigned CNT_W = 32;

   // ---------------------------------------------------------------
   // Codes and widths
   // ---------------------------------------------------------------
   localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
   localparam logic [1:0] MODE_ONE_SHOT = 2'h1;
   localparam logic [1:0] MODE_CONT = 2'h2;
   localparam int unsigned RES_W = 13;
   localparam logic [12:0] NORM_MAX = 13'h07FF;
   localparam logic [12:0] NORM_MIN = 13'h1800;
   localparam logic [7:0] CAL_BYTE = 8'h55;
   localparam logic [3:0] ADDR_RESET = 4'h0;

   typedef enum logic [1:0] {
      CV_IDLE = 2'b00,
      CV_RUN = 2'b01,
      CV_WAIT = 2'b10
   } conv_state_t;

   // Limit register write carrier
   typedef struct packed {
      logic wr_high;
      logic wr_low;
      logic [12:0] value;
   } limit_wr_t;
endpackage

// ---- bench/host_uart_model.sv ----
module host_uart_model (
   input wire logic clk_i,
   output logic line_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Line rests high between frames
   initial line_o = 1'b1;
   // Low start, eight bits LSB first, high stop; four cycles a bit
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk_i);
         line_o <= f[i];
         repeat (3) @(posedge clk_i);
      end
   endtask
endmodule

// ---- bench/tb.sv ----
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import temp_core_pkg::*;
   localparam logic [4:0] LIM = 5'h10, MW = 5'h08, BY = 5'h04, CM = 5'h02, AL = 5'h01;
   localparam int CONV = 20, TOUT = 30, MS = 4;
   logic clk = 0, rst = 1, seen = 0, glob = 0, cval = 0, aload = 0, mwr = 0, ext = 0;
   logic rx, tx, valid, rext, conv, ireset, synced, match, pass_on = 0;
   logic osend = 0, obit = 0;
   logic [1:0] mode = 2'h0, mode_rd, rate = 2'h3;
   logic [3:0] caddr = 4'h0, own_addr, hist = 4'hF;
   logic [7:0] bdata = 8'h00;
   logic [12:0] result, hi, lo;
   logic signed [15:0] raw = 16'sh0190;
   limit_wr_t lw = '0;
   int miscompares = 0, samples_checked = 0, cyc = 0;
   host_uart_model host (.clk_i(clk), .line_o(rx));
   temp_sensor_core #(.ACT_CONV_CYCLES(CONV), .TIMEOUT_CYCLES(TOUT), .MS_CYCLES(MS)) uut (
      .clk_i(clk), .reset_i(rst), .chain_rx_i(rx), .chain_tx_o(tx), .own_send_i(osend),
      .own_bit_i(obit), .byte_seen_i(seen), .byte_data_i(bdata), .cmd_addr_i(caddr),
      .cmd_global_i(glob), .cmd_valid_i(cval), .addr_load_i(aload), .addr_value_i(caddr),
      .mode_wr_i(mwr), .mode_i(mode), .conversion_rate_field_i(rate),
      .extended_range_select_i(ext), .limit_wr_i(lw), .raw_temp_i(raw), .mode_o(mode_rd),
      .result_o(result), .result_valid_o(valid), .result_ext_o(rext), .converting_o(conv),
      .high_limit_o(hi), .low_limit_o(lo), .iface_reset_o(ireset), .iface_synced_o(synced),
      .addr_match_o(match), .own_addr_o(own_addr));
   // Free-running 8 ns clock
   initial forever #4 clk = ~clk;
   // Hang ceiling, and chain output against the input three cycles back
   always @(posedge clk) begin
      #1;
      cyc++;
      hist = {hist[2:0], rx};
      if (pass_on) chk(13'(tx), 13'(hist[3]));
      if (cyc > 30000) begin
         miscompares++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
      if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Case inequality so an unknown never passes
   task automatic chk(input logic [12:0] g, input logic [12:0] e);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // One-cycle strobe with its data; returns once the taking edge has landed
   task automatic go(input logic [4:0] s, input logic [12:0] d);
      @(posedge clk);
      {mwr, seen, cval, aload} <= s[3:0];
      lw <= '{s[4], s[4], d};
      mode <= d[1:0];
      bdata <= d[7:0];
      caddr <= d[3:0];
      glob <= d[4];
      @(posedge clk);
      {mwr, seen, cval, aload} <= 4'h0;
      lw <= '0;
      #1;
   endtask
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   // Bounded wait; a slow converter shows up as a miscompare, not a hang
   task automatic wait_conv(input logic v);
      for (int n = 0; n < 1500 && conv !== v; n++) step();
      chk(13'(conv), 13'(v));
   endtask
   task automatic t_power();
      step();
      chk(13'(conv), 13'h1);
      repeat (10) step();
      chk(13'(valid), 13'h0);
      wait_conv(1'b0);
      chk(result, 13'h0190);
      chk(13'(valid), 13'h1);
   endtask
   task automatic t_format();
      logic [15:0] raws [6] = '{16'h0190, 16'hFFFF, 16'h0960, 16'h0960, 16'hFFFF, 16'hFD80};
      logic [12:0] exps [6] = '{13'h0190, 13'h0FFF, 13'h07FF, 13'h0960, 13'h1FFF, 13'h0D80};
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         raw <= raws[i];
         ext <= (i == 3 || i == 4);
         wait_conv(1'b1);
         wait_conv(1'b0);
         chk(result & (ext ? 13'h1FFF : 13'h0FFF), exps[i]);
         chk(13'(rext), 13'(ext));
      end
   endtask
   task automatic t_limits();
      go(LIM, 13'h1ABC);
      chk(hi, 13'h0ABC);
      @(posedge clk);
      ext <= 1'b1;
      go(LIM, 13'h1ABC);
      chk(lo, 13'h1ABC);
      @(posedge clk);
      ext <= 1'b0;
      step();
      chk(hi, 13'h1ABC);
      go(LIM, 13'h0400);
      chk(hi, 13'h1400);
   endtask
   task automatic t_modes();
      wait_conv(1'b1);
      @(posedge clk);
      raw <= 16'sh0320;
      go(MW, 13'h0);
      wait_conv(1'b0);
      chk(result, 13'h0320);
      repeat (1400) step();
      chk({10'h0, mode_rd, conv}, 13'h0);
      @(posedge clk);
      raw <= 16'sh04B0;
      go(MW, 13'h1);
      step();
      chk({10'h0, mode_rd, conv}, 13'h3);
      wait_conv(1'b0);
      chk({10'h0, mode_rd, conv}, 13'h0);
      chk(result, 13'h04B0);
   endtask
   // Rate 2 then rate 3; idle gap is the period less one conversion
   task automatic t_cont();
      int n;
      for (int c = 2; c < 4; c++) begin
         @(posedge clk);
         rate <= 2'(c);
         go(MW, 13'(c));
         wait_conv(1'b1);
         chk(13'(mode_rd), 13'(c));
         wait_conv(1'b0);
         repeat (50) step();
         chk(13'(conv), 13'h0);
         for (n = 50; n < 1500 && conv !== 1'b1; n++) step();
         chk(13'(n), 13'((c == 2 ? PERIOD_MS_2 : PERIOD_MS_3) * MS - CONV));
         chk(13'(conv), 13'h1);
      end
   endtask
   task automatic t_iface();
      int n;
      go(BY, 13'h12);
      chk(13'(synced), 13'h0);
      go(BY, 13'h55);
      chk(13'(synced), 13'h1);
      repeat (3) begin
         repeat (20) step();
         go(BY, 13'hA5);
      end
      chk(13'(synced), 13'h1);
      for (n = 0; n < 40 && ireset !== 1'b1; n++) step();
      chk(13'(n), 13'(TOUT));
      step();
      chk(13'(synced), 13'h0);
   endtask
   task automatic t_chain();
      pass_on = 1'b1;
      host.send_byte(8'h55);
      host.send_byte(8'h3C);
      repeat (4) step();
      pass_on = 1'b0;
      // Own data breaks the chain; idle line is high, so a low bit is ours
      @(posedge clk);
      osend <= 1'b1;
      obit <= 1'b0;
      step();
      chk(13'(tx), 13'h0);
      @(posedge clk);
      obit <= 1'b1;
      step();
      chk(13'(tx), 13'h1);
      @(posedge clk);
      osend <= 1'b0;
   endtask
   task automatic t_addr();
      go(AL, 13'h5);
      chk(13'(own_addr), 13'h5);
      go(CM, 13'h05);
      chk(13'(match), 13'h1);
      go(CM, 13'h06);
      chk(13'(match), 13'h0);
      go(CM, 13'h16);
      chk(13'(match), 13'h1);
   endtask
   // Reset for eight cycles, then each scenario in turn
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_power();
      t_format();
      t_limits();
      t_modes();
      t_cont();
      t_iface();
      t_chain();
      t_addr();
      finish_test();
   end
endmodule
